// ===== logic/exception_report_restart.v
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "exception_report_restart_regs.vh"
module exception_report_restart (
    // clock, reset, enable
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // pipeline program counter inputs
    input wire [31:0] exec_pc_i,
    input wire [31:0] next_pc_i,
    // trap requests from the priority logic
    input wire trap_take_i,
    input wire trap_async_i,
    input wire trap_curr_i,
    input wire trap_warn_i,
    input wire fetch_fault_i,
    input wire branch_taken_i,
    // bus access observation
    input wire acc_start_i,
    input wire acc_load_i,
    input wire [31:0] acc_addr_i,
    input wire [31:0] acc_wdata_i,
    input wire [7:0] acc_instr_bits_i,
    input wire [7:0] acc_count_i,
    input wire acc_multiple_i,
    input wire acc_set_i,
    input wire acc_lock_i,
    input wire [7:0] acc_target_i,
    input wire acc_done_i,
    input wire acc_target_overwritten_i,
    input wire bus_err_i,
    // interrupt return instruction
    input wire interrupt_return_op_i,
    // restart and trap outputs
    output reg replay_o,
    output reg [31:0] replay_addr_o,
    output reg [31:0] replay_data_o,
    output reg [31:0] replay_ctrl_o,
    output reg data_access_trap_o,
    output reg fetch_trap_o,
    output reg [31:0] prog_counter_zero_o,
    output reg [31:0] prog_counter_one_o,
    output reg [31:0] prog_counter_two_o
);

    // two-flop synchroniser for the external error pin
    reg err_meta;
    reg err_sync;

    reg [31:0] access_addr_report;
    reg [31:0] access_data_report;
    reg [31:0] access_control_report;
    reg [31:0] prog_counter_zero;
    reg [31:0] prog_counter_one;
    reg [31:0] prog_counter_two;
    reg freeze_bit;
    reg acc_busy;
    reg fetch_pending;
    reg [31:0] next_rdata;
    reg next_err;

    wire [3:0] idx = paddr_i[5:2];
    wire aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[7:6] == 2'b00);
    // writes land at the edge that sees the answer, not before
    wire wr_strobe = psel_i && penable_i && pwrite_i && pready_o;
    wire rd_strobe = psel_i && penable_i && !pwrite_i && !pready_o;
    wire ctrl_write = wr_strobe && aligned && (idx == `IDX_CTRL_REPORT);
    // one write select per software-visible register
    wire wr_addr = wr_strobe && aligned && (idx == `IDX_ADDR_REPORT);
    wire wr_data = wr_strobe && aligned && (idx == `IDX_DATA_REPORT);
    wire wr_pc_zero = wr_strobe && aligned && (idx == `IDX_PC_ZERO);
    wire wr_pc_one = wr_strobe && aligned && (idx == `IDX_PC_ONE);
    wire wr_pc_two = wr_strobe && aligned && (idx == `IDX_PC_TWO);
    wire wr_status = wr_strobe && aligned && (idx == `IDX_STATUS);
    wire capture = acc_start_i && !freeze_bit;
    wire warn_capture = trap_take_i && trap_warn_i && acc_busy;
    wire fault_now = acc_busy && err_sync;

    // synchroniser for the error input
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            err_meta <= 1'b0;
            err_sync <= 1'b0;
        end
        else if (clk_en_i)
        begin
            err_meta <= bus_err_i;
            err_sync <= err_meta;
        end
    end

    // read decode
    always @*
    begin
        next_rdata = `RST_WORD;
        next_err = 1'b0;
        if (!aligned)
            next_err = 1'b1;
        else
        begin
            case (idx)
                `IDX_ADDR_REPORT: next_rdata = access_addr_report;
                `IDX_DATA_REPORT: next_rdata = access_data_report;
                `IDX_CTRL_REPORT: next_rdata = access_control_report & `CTRL_WMASK;
                `IDX_PC_ZERO: next_rdata = prog_counter_zero;
                `IDX_PC_ONE: next_rdata = prog_counter_one;
                `IDX_PC_TWO: next_rdata = prog_counter_two;
                `IDX_STATUS: next_rdata = {31'h00000000, freeze_bit};
                default: next_err = 1'b1;
            endcase
        end
    end

    // apb handshake: one wait state, answer in the second access cycle
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= `RST_WORD;
        end
        else if (clk_en_i)
        begin
            if (psel_i && penable_i && !pready_o)
            begin
                pready_o <= 1'b1;
                pslverr_o <= next_err;
                prdata_o <= rd_strobe ? next_rdata : `RST_WORD;
            end
            else
            begin
                pready_o <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    // an access stays open from its start until done or a fault ends it
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            acc_busy <= 1'b0;
        else if (clk_en_i)
        begin
            if (acc_start_i)
                acc_busy <= 1'b1;
            else if (acc_done_i || fault_now)
                acc_busy <= 1'b0;
        end
    end

    // freeze: set on trap entry (a warning trap only with an access open), cleared by return; return beats trap beats software
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            freeze_bit <= `RST_STATUS;
        else if (clk_en_i)
        begin
            if (interrupt_return_op_i)
                freeze_bit <= 1'b0;
            else if (trap_take_i && (!trap_warn_i || warn_capture))
                freeze_bit <= 1'b1;
            else if (wr_status)
                freeze_bit <= pwdata_i[`STAT_FZ];
        end
    end

    // channel address follows every unfrozen access
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            access_addr_report <= `RST_WORD;
        else if (clk_en_i)
        begin
            if (capture)
                access_addr_report <= acc_addr_i;
            else if (wr_addr)
                access_addr_report <= pwdata_i;
        end
    end

    // channel data follows every unfrozen access
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            access_data_report <= `RST_WORD;
        else if (clk_en_i)
        begin
            if (capture)
                access_data_report <= acc_wdata_i;
            else if (wr_data)
                access_data_report <= pwdata_i;
        end
    end

    // control word capture, fault marking, software writes
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            access_control_report <= `RST_WORD;
        else if (clk_en_i)
        begin
            // software writes first, hardware events override
            if (ctrl_write)
                access_control_report <= pwdata_i & `CTRL_WMASK;
            if (capture)
            begin
                access_control_report[`CTRL_TOP_HI:`CTRL_TOP_LO] <= acc_instr_bits_i;
                access_control_report[`CTRL_CR_HI:`CTRL_CR_LO] <= acc_count_i;
                access_control_report[`CTRL_LS] <= acc_load_i;
                access_control_report[`CTRL_ML] <= acc_multiple_i;
                access_control_report[`CTRL_ST] <= acc_set_i;
                access_control_report[`CTRL_LA] <= acc_lock_i;
                access_control_report[`CTRL_RSVD] <= 1'b0;
                access_control_report[`CTRL_TF] <= 1'b0;
                access_control_report[`CTRL_TR_HI:`CTRL_TR_LO] <= acc_target_i;
                access_control_report[`CTRL_NN] <= 1'b0;
                access_control_report[`CTRL_CV] <= 1'b1;
            end
            else if (acc_done_i && acc_busy && !freeze_bit)
                access_control_report[`CTRL_CV] <= 1'b0;
            if (fault_now && !freeze_bit)
                access_control_report[`CTRL_TF] <= 1'b1; // set wins over clear
            if (acc_busy && acc_target_overwritten_i && access_control_report[`CTRL_LS]
                && !freeze_bit)
                access_control_report[`CTRL_NN] <= 1'b1;
        end
    end

    // prefetch faults wait for execution and die on a taken branch
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            fetch_pending <= 1'b0;
            fetch_trap_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            fetch_trap_o <= 1'b0;
            if (branch_taken_i)
                fetch_pending <= 1'b0;
            else if (fetch_fault_i)
                fetch_pending <= 1'b1;
            if (fetch_pending && !branch_taken_i && trap_take_i)
            begin
                fetch_trap_o <= 1'b1;
                fetch_pending <= 1'b0;
            end
        end
    end

    // pc zero holds the instruction after the trap point
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            prog_counter_zero <= `RST_WORD;
        else if (clk_en_i)
        begin
            if (trap_take_i)
                prog_counter_zero <= next_pc_i;
            else if (wr_pc_zero)
                prog_counter_zero <= pwdata_i;
        end
    end

    // pc one and two on trap entry, chosen by trap category
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            prog_counter_one <= `RST_WORD;
            prog_counter_two <= `RST_WORD;
        end
        else if (clk_en_i)
        begin
            if (wr_pc_one)
                prog_counter_one <= pwdata_i;
            if (wr_pc_two)
                prog_counter_two <= pwdata_i;
            if (trap_take_i)
            begin
                if (trap_async_i)
                    prog_counter_one <= exec_pc_i; // first unexecuted
                else if (trap_curr_i)
                    prog_counter_one <= exec_pc_i;
                else
                begin
                    prog_counter_one <= next_pc_i;
                    prog_counter_two <= exec_pc_i;
                end
            end
        end
    end

    // restart request on interrupt return and the channel copy it carries
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            replay_o <= 1'b0;
            replay_addr_o <= `RST_WORD;
            replay_data_o <= `RST_WORD;
            replay_ctrl_o <= `RST_WORD;
        end
        else if (clk_en_i)
        begin
            replay_o <= interrupt_return_op_i && access_control_report[`CTRL_CV]
                && !access_control_report[`CTRL_NN];
            replay_addr_o <= access_addr_report;
            replay_data_o <= access_data_report;
            replay_ctrl_o <= access_control_report; // count resumes mid-sequence
        end
    end

    // data access trap stands while the faulted bit is set
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            data_access_trap_o <= 1'b0;
        else if (clk_en_i)
            data_access_trap_o <= access_control_report[`CTRL_TF];
    end

    // program counter copies for the handler
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            prog_counter_zero_o <= `RST_WORD;
            prog_counter_one_o <= `RST_WORD;
            prog_counter_two_o <= `RST_WORD;
        end
        else if (clk_en_i)
        begin
            prog_counter_zero_o <= prog_counter_zero;
            prog_counter_one_o <= prog_counter_one;
            prog_counter_two_o <= prog_counter_two;
        end
    end

endmodule
`default_nettype wire

// ===== logic/exception_report_restart_regs.vh
`ifndef EXCEPTION_REPORT_RESTART_REGS_VH
`define EXCEPTION_REPORT_RESTART_REGS_VH
`define IDX_ADDR_REPORT 4'h4
`define IDX_DATA_REPORT 4'h5
`define IDX_CTRL_REPORT 4'h6
`define IDX_PC_ZERO 4'h7
`define IDX_PC_ONE 4'h8
`define IDX_PC_TWO 4'h9
`define IDX_STATUS 4'ha
`define CTRL_TOP_HI 31
`define CTRL_TOP_LO 24
`define CTRL_CR_HI 23
`define CTRL_CR_LO 16
`define CTRL_LS 15
`define CTRL_ML 14
`define CTRL_ST 13
`define CTRL_LA 12
`define CTRL_RSVD 11
`define CTRL_TF 10
`define CTRL_TR_HI 9
`define CTRL_TR_LO 2
`define CTRL_NN 1
`define CTRL_CV 0
`define CTRL_WMASK 32'hfffff7ff
`define STAT_FZ 0
`define RST_WORD 32'h00000000
`define RST_STATUS 1'b0
`endif

// ===== tb/exception_report_restart_checker.sv
`timescale 1ns/1ps
`default_nettype none
module exception_report_restart_checker (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // register bus
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // traps and program counters
    input wire logic trap_take_i,
    input wire logic trap_async_i,
    input wire logic trap_curr_i,
    input wire logic [31:0] exec_pc_i,
    input wire logic [31:0] next_pc_i,
    input wire logic [31:0] prog_counter_one_o,
    input wire logic [31:0] prog_counter_two_o,
    // fault and restart
    input wire logic bus_err_i,
    input wire logic data_access_trap_o,
    input wire logic interrupt_return_op_i,
    input wire logic replay_o,
    input wire logic [31:0] replay_ctrl_o
);
    // one clock domain, all checks off in reset
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // one wait state on the register bus
    a_apb_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("bus answer late");
    a_error_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    // program counters after each kind of trap
    a_pc_curr_kept: assert property (
        trap_take_i && trap_curr_i && !trap_async_i
        |-> ##2 prog_counter_one_o == $past(exec_pc_i, 2)) else $error("pc one wrong");
    a_pc_async_next: assert property (
        trap_take_i && trap_async_i |-> ##2 prog_counter_one_o == $past(exec_pc_i, 2))
        else $error("pc one wrong on async");
    a_pc_two_cause: assert property (
        trap_take_i && !trap_curr_i && !trap_async_i
        |-> ##2 prog_counter_two_o == $past(exec_pc_i, 2) && prog_counter_one_o == $past(
        next_pc_i, 2)) else $error("pc two wrong");
    // fault trap follows the synchronised error input
    a_trap_after_err: assert property ($rose(data_access_trap_o) |->
        $past(bus_err_i, 2) || $past(bus_err_i, 3) || $past(bus_err_i, 4))
        else $error("trap without error");
    // restart only after return, only when valid and needed
    a_replay_cause: assert property (replay_o |-> $past(interrupt_return_op_i))
        else $error("replay without return");
    a_replay_clean: assert property (replay_o |-> replay_ctrl_o[0] && !replay_ctrl_o[1])
        else $error("replay of invalid access");
    c_replay: cover property (replay_o);
    c_fault: cover property ($rose(data_access_trap_o));
    c_refused: cover property (pslverr_o);
endmodule
bind exception_report_restart exception_report_restart_checker i_exception_report_restart_checker (.*);
`default_nettype wire

// ===== tb/exception_report_restart_tb.sv
`timescale 1ns/1ps
`default_nettype none
module exception_report_restart_tb;
    // design inputs, quiet at time zero
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, interrupt_return_op_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h0, acc_instr_bits_i = 8'h0, acc_count_i = 8'h0, acc_target_i = 8'h0;
    logic [31:0] pwdata_i = 32'h0, exec_pc_i = 32'h0, next_pc_i = 32'h0;
    logic [31:0] acc_addr_i = 32'h0, acc_wdata_i = 32'h0;
    logic trap_take_i = 1'b0, trap_async_i = 1'b0, trap_curr_i = 1'b0, trap_warn_i = 1'b0;
    logic fetch_fault_i = 1'b0, branch_taken_i = 1'b0, acc_start_i = 1'b0, acc_load_i = 1'b0;
    logic acc_multiple_i = 1'b0, acc_set_i = 1'b0, acc_lock_i = 1'b0;
    logic acc_target_overwritten_i = 1'b0, fail = 1'b0;
    logic [3:0] lat = 4'h0;
    // outputs and bench state
    logic [31:0] prdata_o, replay_addr_o, replay_data_o, replay_ctrl_o, rd, ex;
    logic [31:0] prog_counter_zero_o, prog_counter_one_o, prog_counter_two_o;
    logic pready_o, pslverr_o, replay_o, data_access_trap_o, fetch_trap_o;
    logic acc_done_i, bus_err_i, er;
    int failures = 0, n_compared = 0, cyc = 0, replays = 0, fetch_traps = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    exception_report_restart i_exception_report_restart (.*);
    mem_partner i_mem_partner (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(acc_start_i),
        .lat_i(lat),
        .fail_i(fail),
        .done_o(acc_done_i),
        .err_o(bus_err_i)
    );
    task automatic end_sim();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // cycle limit and restart pulse count
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (replay_o === 1'b1)
            replays++;
        if (fetch_trap_o === 1'b1)
            fetch_traps++;
        if (cyc == 3000)
        begin
            failures++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
        end
    endtask
    // one register bus transfer, waits for ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // start one bus access, expected control word has valid set
    task automatic acc(input logic ld, input logic [31:0] a, input logic [7:0] ib, cnt,
                       input logic [2:0] fl, input logic [7:0] tr);
        @(posedge ref_clk_i);
        acc_load_i <= ld;
        acc_addr_i <= a;
        acc_wdata_i <= ~a;
        acc_instr_bits_i <= ib;
        acc_count_i <= cnt;
        {acc_multiple_i, acc_set_i, acc_lock_i} <= fl;
        acc_target_i <= tr;
        acc_start_i <= 1'b1;
        ex = {ib, cnt, ld, fl, 2'b00, tr, 2'b01};
        @(posedge ref_clk_i);
        acc_start_i <= 1'b0;
    endtask
    task automatic trap(input logic as, cu, input logic [31:0] pc);
        @(posedge ref_clk_i);
        trap_take_i <= 1'b1;
        trap_async_i <= as;
        trap_curr_i <= cu;
        exec_pc_i <= pc;
        next_pc_i <= pc + 32'h4;
        @(posedge ref_clk_i);
        trap_take_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic interrupt_return_op_pulse();
        @(posedge ref_clk_i);
        interrupt_return_op_i <= 1'b1;
        @(posedge ref_clk_i);
        interrupt_return_op_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        apb(1'b0, 8'h3c, 32'h0);
        chk({rd[31:1], er}, 32'h1);
        // stalled store of a multiple sequence, frozen, then restarted
        acc(1'b0, 32'h8000_1234, 8'ha5, 8'h1c, 3'b100, 8'h83);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h8000_1234);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h7fff_edcb);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, ex);
        trap(1'b1, 1'b0, 32'h0000_2000);
        acc(1'b1, 32'h0000_0040, 8'h11, 8'h00, 3'b000, 8'h05);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h8000_1234);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0000_2000);
        interrupt_return_op_pulse();
        chk(replay_addr_o, 32'h8000_1234);
        chk(32'(replays), 32'h1);
        // prompt load and set with lock completes
        lat <= 4'h2;
        acc(1'b1, 32'h0000_0100, 8'h3c, 8'h00, 3'b011, 8'h40);
        repeat (4) @(posedge ref_clk_i);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, ex ^ 32'h1);
        // load whose target was already written is not replayed
        lat <= 4'h0;
        acc_target_overwritten_i <= 1'b1;
        acc(1'b1, 32'h0000_0200, 8'h0f, 8'h00, 3'b000, 8'h80);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, ex | 32'h2);
        trap(1'b1, 1'b0, 32'h0000_3000);
        interrupt_return_op_pulse();
        chk(32'(replays), 32'h1);
        acc_target_overwritten_i <= 1'b0;
        // bus error faults the access, handler clears it
        lat <= 4'h2;
        fail <= 1'b1;
        acc(1'b0, 32'h0000_0300, 8'h22, 8'h00, 3'b000, 8'h10);
        repeat (8) @(posedge ref_clk_i);
        chk({31'h0, data_access_trap_o}, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, ex | 32'h400);
        apb(1'b1, 8'h18, 32'h0000_0800);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, data_access_trap_o}, 32'h0);
        fail <= 1'b0;
        // instruction traps of both kinds, prefetch fault taken then discarded
        @(posedge ref_clk_i);
        fetch_fault_i <= 1'b1;
        @(posedge ref_clk_i);
        fetch_fault_i <= 1'b0;
        trap(1'b0, 1'b1, 32'h0000_5000);
        chk(32'(fetch_traps), 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0000_5000);
        interrupt_return_op_pulse();
        @(posedge ref_clk_i);
        fetch_fault_i <= 1'b1;
        @(posedge ref_clk_i);
        fetch_fault_i <= 1'b0;
        branch_taken_i <= 1'b1;
        @(posedge ref_clk_i);
        branch_taken_i <= 1'b0;
        trap(1'b0, 1'b0, 32'h0000_6000);
        chk(32'(fetch_traps), 32'h1);
        chk(prog_counter_zero_o, 32'h0000_6004);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0000_6004);
        apb(1'b0, 8'h24, 32'h0);
        chk(rd, 32'h0000_6000);
        interrupt_return_op_pulse();
        chk(32'(replays), 32'h1);
        // warning trap freezes the channel only with an access open
        lat <= 4'h0;
        trap_warn_i <= 1'b1;
        trap(1'b1, 1'b0, 32'h0000_7000);
        acc(1'b0, 32'h0000_0400, 8'h5a, 8'h03, 3'b100, 8'h21);
        trap(1'b1, 1'b0, 32'h0000_7100);
        trap_warn_i <= 1'b0;
        acc(1'b0, 32'h0000_0500, 8'h5a, 8'h03, 3'b100, 8'h21);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0000_0400);
        interrupt_return_op_pulse();
        chk(replay_ctrl_o, ex);
        chk(replay_data_o, 32'hffff_fbff);
        chk(32'(replays), 32'h2);
        end_sim();
    end
endmodule
`default_nettype wire

// ===== tb/mem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // access request and answer
    input wire logic start_i,
    input wire logic [3:0] lat_i,
    input wire logic fail_i,
    output var logic done_o,
    output wire logic err_o
);
    logic [3:0] cnt;
    logic [2:0] err_cnt;
    // latency zero means the access never ends
    always @(posedge ref_clk_i)
    begin
        done_o <= 1'b0;
        if (err_cnt != 3'h0)
            err_cnt <= err_cnt - 3'h1;
        if (sys_rst_i)
        begin
            cnt <= 4'h0;
            err_cnt <= 3'h0;
        end
        else if (start_i)
            cnt <= lat_i;
        else if (cnt == 4'h1)
        begin
            cnt <= 4'h0;
            if (fail_i)
                err_cnt <= 3'h5;
            else
                done_o <= 1'b1;
        end
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
    assign err_o = err_cnt != 3'h0;
endmodule
`default_nettype wire
